// ### rtl/emb_regs.svh
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH
`define EMB_IO_BANKS       8
`define EMB_SD_BANKS       2
`define EMB_IO_BANK_SPAN   32'h0100_0000
`define EMB_IO_TOP         32'h0800_0000
`define EMB_SD0_BASE       32'h4000_0000
`define EMB_SD1_BASE       32'h8000_0000
`define EMB_SD_SPAN        32'h0800_0000
`define EMB_ADDR_W         24
`define EMB_DATA_W         32
`define EMB_IO_CYCLES      4'h3
`define EMB_SD_CYCLES      4'h2
`define EMB_NO_SELECT      8'hff
`endif

// ### rtl/emb_pkg.sv
`include "emb_regs.svh"
package emb_pkg;
    typedef enum logic [1:0] {EMB_W8, EMB_W16, EMB_W32, EMB_WRSV} emb_width_t;
    typedef enum logic [1:0] {EMB_SZ_BYTE, EMB_SZ_HALF, EMB_SZ_WORD, EMB_SZ_RSV} emb_size_t;
    typedef enum logic [2:0] {EMB_IDLE, EMB_IO, EMB_SD_RAS, EMB_SD_CAS, EMB_DONE,
                              EMB_GRANTED} emb_state_t;
endpackage : emb_pkg

// ### rtl/emb_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module emb_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] stage1;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= '0;
            o_q    <= '0;
        end else begin
            stage1 <= i_d;
            o_q    <= stage1;
        end
    end
endmodule : emb_sync2
`default_nettype wire

// ### rtl/emb_bank_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "emb_regs.svh"
// Overview of operation
// - ten banks: eight static, two sdram
// - static bank n at n times 16 MB
// - sdram banks at 0x40000000 and 0x80000000
// - static banks 16 MB, 24-bit address
// - bank bases fixed; reset restores defaults
// - sdram range access generates sdram signalling
// - all static banks share one access path
// - one active-low select per static bank
// - output enable low only on static reads
// - wait input stretches static access
// - outside master request answered by grant
// - bank 0 width from strap pins
// - write strobe shared by sdram and 16-bit static writes only, four byte enables
// - sdram cke, two selects, ras, cas
// - shared address/data, separate control groups
// - narrow devices split/merge word accesses
// - endian strap selects byte ordering
// - big-endian word store lanes dcba
// - sub-word stores replicated, lane by offset
// - big-endian loads reversed, sub-word replicated
// - system clock halved by a toggle flop, driven out on pin
module emb_bank_if
    import emb_pkg::*;
#(
    parameter int BANKS = `EMB_IO_BANKS
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  wire logic        i_write,
    input  wire logic [1:0]  i_size,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [1:0]  i_bank_width,
    input  wire logic [1:0]  i_bank0_width_strap,
    input  wire logic        i_big_endian,
    input  wire logic        i_slow_device_wait_n,
    input  wire logic        i_ext_master_request,
    input  wire logic [31:0] i_data,
    output logic             o_ack,
    output logic             o_err,
    output logic [31:0]      o_rdata,
    output logic [23:0]      o_addr,
    output logic             o_addr_oe,
    output logic [31:0]      o_data,
    output logic             o_data_oe,
    output logic [7:0]       o_static_bank_select_n,
    output logic             o_read_output_enable_n,
    output logic             o_shared_write_strobe_n,
    output logic [3:0]       o_byte_lane_enable_n,
    output logic             o_sdram_clk_en,
    output logic [1:0]       o_sdram_select_n,
    output logic             o_sdram_row_strobe_n,
    output logic             o_sdram_col_strobe_n,
    output logic             o_ext_master_grant,
    output logic             o_sys_clock_out
);
    emb_state_t  state;
    logic        wait_n;
    logic        xreq;
    logic [3:0]  cnt;
    logic [1:0]  beat;
    logic [1:0]  beats_left;
    logic [31:0] acc;
    logic        is_io;
    logic        is_sd0;
    logic        is_sd1;
    logic [2:0]  bank;
    logic [1:0]  dev_w;
    logic [1:0]  lane;
    logic [31:0] lat_addr;
    logic        lat_write;
    logic [1:0]  lat_size;
    logic [31:0] lat_wdata;
    logic [1:0]  lat_w;
    logic        lat_big;
    logic [1:0]  next_beats;
    logic [31:0] next_bus_wdata;
    logic [31:0] cur_ext_addr;
    logic [1:0]  cur_lane;
    logic [31:0] out_data;
    logic [3:0]  out_be_n;
    logic [31:0] merged;
    logic [31:0] sdr;
    logic        sys_clk_div;

    emb_sync2 #(.W(2)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_slow_device_wait_n, i_ext_master_request}),
        .o_q   ({wait_n, xreq})
    );

    // fixed decode
    always_comb begin
        is_io  = (i_addr < `EMB_IO_TOP);
        is_sd0 = (i_addr >= `EMB_SD0_BASE) && (i_addr < `EMB_SD0_BASE + `EMB_SD_SPAN);
        is_sd1 = (i_addr >= `EMB_SD1_BASE) && (i_addr < `EMB_SD1_BASE + `EMB_SD_SPAN);
        bank   = i_addr[26:24];
        dev_w  = (bank == 3'h0) ? i_bank0_width_strap : i_bank_width;
        if (!is_io) begin
            dev_w = EMB_W32;
        end
    end

    // beats per access for narrow devices
    always_comb begin
        next_beats = 2'h0;
        if (dev_w == EMB_W8) begin
            next_beats = (i_size == EMB_SZ_WORD) ? 2'h3 : (i_size == EMB_SZ_HALF) ? 2'h1 : 2'h0;
        end else if (dev_w == EMB_W16 && i_size == EMB_SZ_WORD) begin
            next_beats = 2'h1;
        end
    end

    // internal bus replication of sub-word stores
    always_comb begin
        case (i_size)
            EMB_SZ_BYTE: next_bus_wdata = {4{i_wdata[7:0]}};
            EMB_SZ_HALF: next_bus_wdata = {2{i_wdata[15:0]}};
            default:     next_bus_wdata = i_wdata;
        endcase
    end

    // current external address and byte lane of the beat
    always_comb begin
        cur_ext_addr = lat_addr + {30'h0, beat} * ((lat_w == EMB_W16) ? 32'h2 : 32'h1);
        cur_lane     = cur_ext_addr[1:0];
        if (lat_w == EMB_W16) begin
            cur_lane = {cur_ext_addr[1], 1'b0};
        end
    end

    // store lane steering
    always_comb begin
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] idx;
        b0 = 8'h0;
        b1 = 8'h0;
        idx = 2'h0;
        out_data = 32'h0;
        out_be_n = 4'hf;
        if (lat_w == EMB_W32) begin
            if (lat_big) begin
                out_data = {lat_wdata[7:0], lat_wdata[15:8], lat_wdata[23:16], lat_wdata[31:24]};
            end else begin
                out_data = lat_wdata;
            end
            case (lat_size)
                EMB_SZ_BYTE: out_be_n = ~(4'h1 << cur_lane);
                EMB_SZ_HALF: out_be_n = cur_lane[1] ? 4'h3 : 4'hc;
                default:     out_be_n = 4'h0;
            endcase
        end else if (lat_w == EMB_W16) begin
            idx = lat_big ? (beat[0] ? 2'h1 : 2'h0) : (beat[0] ? 2'h1 : 2'h0);
            if (lat_size == EMB_SZ_WORD) begin
                {b1, b0} = lat_big ? (idx[0] ? {lat_wdata[7:0], lat_wdata[15:8]}
                                             : {lat_wdata[23:16], lat_wdata[31:24]})
                                   : (idx[0] ? lat_wdata[31:16] : lat_wdata[15:0]);
            end else begin
                {b1, b0} = lat_big ? {lat_wdata[7:0], lat_wdata[15:8]} : lat_wdata[15:0];
            end
            out_data = {16'h0, b1, b0};
            out_be_n = (lat_size == EMB_SZ_BYTE) ? ~(4'h1 << {1'b0, lat_addr[0]}) : 4'hc;
        end else begin
            // big endian sends the high byte first, also for replicated halfwords
            idx = lat_big ? 2'h3 - beat : beat;
            out_data = {24'h0, lat_wdata[8*idx +: 8]};
            out_be_n = 4'he;
        end
    end

    // load lane reversal and merge
    always_comb begin
        sdr = lat_big ? {i_data[7:0], i_data[15:8], i_data[23:16], i_data[31:24]} : i_data;
        merged = acc;
        if (lat_w == EMB_W32) begin
            merged = sdr;
        end else if (lat_w == EMB_W16) begin
            if (lat_big) begin
                merged = beat[0] ? {acc[31:16], i_data[7:0], i_data[15:8]}
                                 : {i_data[7:0], i_data[15:8], 16'h0};
            end else begin
                merged = beat[0] ? {i_data[15:0], acc[15:0]} : {16'h0, i_data[15:0]};
            end
        end else begin
            merged[8*(lat_big ? 2'h3 - beat : beat) +: 8] = i_data[7:0];
        end
    end

    // access sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state      <= EMB_IDLE;
            cnt        <= 4'h0;
            beat       <= 2'h0;
            beats_left <= 2'h0;
            acc        <= 32'h0;
            lat_addr   <= 32'h0;
            lat_write  <= 1'b0;
            lat_size   <= 2'h0;
            lat_wdata  <= 32'h0;
            lat_w      <= 2'h0;
            lat_big    <= 1'b0;
        end else begin
            case (state)
                EMB_IDLE: begin
                    beat <= 2'h0;
                    acc  <= 32'h0;
                    if (xreq) begin
                        state <= EMB_GRANTED;
                    end else if (i_req && (is_io || is_sd0 || is_sd1)) begin
                        lat_addr   <= i_addr;
                        lat_write  <= i_write;
                        lat_size   <= i_size;
                        lat_wdata  <= next_bus_wdata;
                        lat_w      <= dev_w;
                        lat_big    <= i_big_endian;
                        beats_left <= next_beats;
                        cnt        <= is_io ? `EMB_IO_CYCLES : `EMB_SD_CYCLES;
                        state      <= is_io ? EMB_IO : EMB_SD_RAS;
                    end else if (i_req) begin
                        lat_addr <= i_addr;
                        state    <= EMB_DONE;
                    end
                end
                EMB_IO: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else if (wait_n) begin
                        acc <= merged;
                        if (beats_left != 2'h0) begin
                            beats_left <= beats_left - 2'h1;
                            beat       <= beat + 2'h1;
                            cnt        <= `EMB_IO_CYCLES;
                        end else begin
                            state <= EMB_DONE;
                        end
                    end
                end
                EMB_SD_RAS: begin
                    state <= EMB_SD_CAS;
                end
                EMB_SD_CAS: begin
                    if (cnt != 4'h0) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        acc   <= merged;
                        state <= EMB_DONE;
                    end
                end
                EMB_DONE: begin
                    state <= EMB_IDLE;
                end
                EMB_GRANTED: begin
                    if (!xreq) begin
                        state <= EMB_IDLE;
                    end
                end
                default: state <= EMB_IDLE;
            endcase
        end
    end

    // registered pin drive
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_addr                  <= 24'h0;
            o_addr_oe               <= 1'b0;
            o_data                  <= 32'h0;
            o_data_oe               <= 1'b0;
            o_static_bank_select_n  <= `EMB_NO_SELECT;
            o_read_output_enable_n  <= 1'b1;
            o_shared_write_strobe_n <= 1'b1;
            o_byte_lane_enable_n    <= 4'hf;
            o_sdram_clk_en          <= 1'b0;
            o_sdram_select_n        <= 2'h3;
            o_sdram_row_strobe_n    <= 1'b1;
            o_sdram_col_strobe_n    <= 1'b1;
            o_ext_master_grant      <= 1'b0;
        end else begin
            o_ext_master_grant      <= (state == EMB_GRANTED) && xreq;
            o_addr_oe               <= (state != EMB_GRANTED);
            o_addr                  <= cur_ext_addr[`EMB_ADDR_W-1:0];
            o_data                  <= out_data;
            o_data_oe               <= (state == EMB_IO || state == EMB_SD_CAS) && lat_write;
            o_static_bank_select_n  <= (state == EMB_IO) ? ~(8'h1 << lat_addr[26:24])
                                                         : `EMB_NO_SELECT;
            o_read_output_enable_n  <= !((state == EMB_IO) && !lat_write);
            o_shared_write_strobe_n <= !(lat_write && ((state == EMB_SD_CAS) ||
                                        (state == EMB_IO && lat_w == EMB_W16)));
            o_byte_lane_enable_n    <= (state == EMB_IO || state == EMB_SD_CAS) ? out_be_n
                                                                               : 4'hf;
            o_sdram_clk_en          <= 1'b1;
            o_sdram_select_n        <= (state == EMB_SD_RAS || state == EMB_SD_CAS)
                                       ? (lat_addr[31] ? 2'h1 : 2'h2) : 2'h3;
            o_sdram_row_strobe_n    <= !(state == EMB_SD_RAS);
            o_sdram_col_strobe_n    <= !(state == EMB_SD_CAS && cnt == 4'h0);
        end
    end

    // answer to internal master
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack   <= 1'b0;
            o_err   <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            o_ack   <= (state == EMB_DONE);
            o_err   <= (state == EMB_DONE) && !(lat_addr < `EMB_IO_TOP
                       || lat_addr - `EMB_SD0_BASE < `EMB_SD_SPAN
                       || lat_addr - `EMB_SD1_BASE < `EMB_SD_SPAN);
            if (state == EMB_DONE) begin
                case (lat_size)
                    EMB_SZ_BYTE: o_rdata <= {4{acc[8*(lat_big ? 2'h3 - lat_addr[1:0]
                                                     : lat_addr[1:0]) +: 8]}};
                    EMB_SZ_HALF: o_rdata <= {2{(lat_addr[1] ^ lat_big) ? acc[31:16] : acc[15:0]}};
                    default:     o_rdata <= acc;
                endcase
            end
        end
    end

    // system clock out, toggled so it comes from a flop
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sys_clk_div <= 1'b0;
        end else begin
            sys_clk_div <= ~sys_clk_div;
        end
    end
    assign o_sys_clock_out = sys_clk_div;

    a_unmapped_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == EMB_IDLE && i_req && !xreq && !is_io && !is_sd0 && !is_sd1)
        |=> ##1 o_static_bank_select_n == `EMB_NO_SELECT && o_sdram_select_n == 2'h3)
        else $error("unmapped access selected a device");
    a_one_select: assert property (@(posedge i_clk) disable iff (i_rst)
        $countones(~o_static_bank_select_n) <= 1)
        else $error("more than one bank select");
    a_oe_read: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_read_output_enable_n |-> $past(state == EMB_IO && !lat_write))
        else $error("output enable outside read");
    a_wait_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == EMB_IO && cnt == 4'h0 && !wait_n) |=> state == EMB_IO)
        else $error("wait not honoured");
    a_grant_release: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ext_master_grant |-> !o_addr_oe)
        else $error("pins driven while granted");
    a_grant_follows: assert property (@(posedge i_clk) disable iff (i_rst)
        (state == EMB_IDLE && xreq) ##1 xreq |=> o_ext_master_grant)
        else $error("grant missing");
    a_sd_ras_cas: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_sdram_row_strobe_n) |-> ##[1:4] !o_sdram_col_strobe_n)
        else $error("cas did not follow ras");
    a_sd_bank_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_sdram_row_strobe_n |-> o_sdram_select_n != 2'h3)
        else $error("sdram strobe without select");
    c_io_read: cover property (@(posedge i_clk) !o_read_output_enable_n);
    c_sd_write: cover property (@(posedge i_clk) !o_shared_write_strobe_n && !o_sdram_col_strobe_n);
    c_granted: cover property (@(posedge i_clk) o_ext_master_grant);
endmodule : emb_bank_if
`default_nettype wire

// ### testbench/emb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_clr,
    input  wire logic [3:0]  i_wait_len,
    input  wire logic [23:0] i_addr,
    input  wire logic [31:0] i_data,
    input  wire logic        i_data_oe,
    input  wire logic [7:0]  i_sel_n,
    input  wire logic        i_oe_n,
    input  wire logic [3:0]  i_be_n,
    input  wire logic [1:0]  i_sd_n,
    input  wire logic        i_ras_n,
    input  wire logic        i_cas_n,
    output logic      [31:0] o_data,
    output logic             o_wait_n,
    output logic      [31:0] o_mem,
    output logic      [7:0]  o_sel_acc,
    output logic      [1:0]  o_sd_acc,
    output logic      [3:0]  o_be_acc,
    output logic             o_oe_seen,
    output logic             o_rc_seen,
    output logic      [3:0]  o_beats
);
    logic [3:0]  wcnt;
    logic [23:0] last_addr;
    logic [31:0] last;
    logic        was_act;
    logic        ras_seen;
    logic        cas_seen;
    logic        act;
    assign act       = ~&i_sel_n;
    // wait goes low with the select so that it clears the two-flop sync in time
    assign o_wait_n  = !(act && (was_act ? wcnt != 4'h0 : i_wait_len != 4'h0));
    assign o_rc_seen = ras_seen & cas_seen;
    // released bus shows the inverse of the last value, never a held copy
    assign o_data    = (act && !i_oe_n) ? o_mem : ~last;
    initial begin
        {wcnt, last_addr, last, was_act, ras_seen, cas_seen, o_mem, o_beats} = '0;
        {o_oe_seen, o_sel_acc, o_sd_acc, o_be_acc} = 15'h7fff;
    end
    always @(posedge i_clk) begin
        was_act   <= act;
        last_addr <= i_addr;
        if (act && !i_oe_n) last <= o_mem;
        // slow device holds wait for a set number of cycles per select
        if (act && !was_act) wcnt <= i_wait_len;
        else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
        if (act && (!was_act || i_addr != last_addr)) o_beats <= o_beats + 4'h1;
        for (int k = 0; k < 4; k++) begin
            if (act && i_oe_n && i_data_oe && !i_be_n[k]) o_mem[8*k +: 8] <= i_data[8*k +: 8];
        end
        o_sel_acc <= o_sel_acc & i_sel_n;
        o_sd_acc  <= o_sd_acc & i_sd_n;
        if (act && i_oe_n && i_data_oe) o_be_acc <= o_be_acc & i_be_n;
        if (act && !i_oe_n) o_oe_seen <= 1'b1;
        if (!i_ras_n) ras_seen <= 1'b1;
        if (!i_cas_n) cas_seen <= 1'b1;
        if (i_clr) begin
            {ras_seen, cas_seen, o_oe_seen, o_beats} <= '0;
            {o_sel_acc, o_sd_acc, o_be_acc} <= 14'h3fff;
        end
    end
endmodule : emb_mem_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import emb_pkg::*;
    logic        i_clk, i_rst, i_req, i_write, i_big_endian, i_ext_master_request;
    logic [1:0]  i_size, i_bank_width, i_bank0_width_strap, o_sdram_select_n, sd_acc;
    logic [31:0] i_addr, i_wdata, i_data, o_rdata, o_data, mem, rdata;
    logic [23:0] o_addr;
    logic [7:0]  o_static_bank_select_n, sel_acc;
    logic [3:0]  o_byte_lane_enable_n, be_acc, beats, wait_len;
    logic        o_ack, o_err, o_addr_oe, o_data_oe, o_read_output_enable_n;
    logic        o_shared_write_strobe_n, o_sdram_clk_en, o_sdram_row_strobe_n;
    logic        o_sdram_col_strobe_n, o_ext_master_grant, o_sys_clock_out;
    logic        i_slow_device_wait_n, clr, oe_seen, rc_seen, err;
    int          n_mismatch, num_checks, cyc, lat, we_cnt, k;
    logic [31:0] row_addr [14] = '{32'h00ff_fffc, 32'h01ff_fffc, 32'h02ff_fffc,
        32'h03ff_fffc, 32'h04ff_fffc, 32'h05ff_fffc, 32'h06ff_fffc, 32'h07ff_fffc,
        32'h0800_0000, 32'h4000_0000, 32'h47ff_fffc, 32'h4800_0000, 32'h8000_0000,
        32'hf000_0000};
    logic [7:0]  row_sel [14] = '{8'hfe, 8'hfd, 8'hfb, 8'hf7, 8'hef, 8'hdf, 8'hbf,
        8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [1:0]  row_sd [14] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3,
        2'h3, 2'h2, 2'h2, 2'h3, 2'h1, 2'h3};

    emb_bank_if emb_bank_if_inst (
        .i_clk, .i_rst, .i_req, .i_write, .i_size, .i_addr, .i_wdata, .i_bank_width,
        .i_bank0_width_strap, .i_big_endian, .i_slow_device_wait_n, .i_ext_master_request,
        .i_data, .o_ack, .o_err, .o_rdata, .o_addr, .o_addr_oe, .o_data, .o_data_oe,
        .o_static_bank_select_n, .o_read_output_enable_n, .o_shared_write_strobe_n,
        .o_byte_lane_enable_n, .o_sdram_clk_en, .o_sdram_select_n, .o_sdram_row_strobe_n,
        .o_sdram_col_strobe_n, .o_ext_master_grant, .o_sys_clock_out
    );
    emb_mem_model emb_mem_model_inst (
        .i_clk, .i_clr(clr), .i_wait_len(wait_len), .i_addr(o_addr), .i_data(o_data),
        .i_data_oe(o_data_oe), .i_sel_n(o_static_bank_select_n),
        .i_oe_n(o_read_output_enable_n), .i_be_n(o_byte_lane_enable_n),
        .i_sd_n(o_sdram_select_n), .i_ras_n(o_sdram_row_strobe_n),
        .i_cas_n(o_sdram_col_strobe_n), .o_data(i_data), .o_wait_n(i_slow_device_wait_n),
        .o_mem(mem), .o_sel_acc(sel_acc), .o_sd_acc(sd_acc), .o_be_acc(be_acc),
        .o_oe_seen(oe_seen), .o_rc_seen(rc_seen), .o_beats(beats)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(negedge o_shared_write_strobe_n) we_cnt++;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task done(input string s);
        $display("test %s done", s);
    endtask : done

    // one request held until its acknowledge, model flags cleared first
    task access(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
        i_write = w;
        i_size = sz;
        i_addr = a;
        i_wdata = d;
        clr = 1'b1;
        @(posedge i_clk);
        #1;
        clr = 1'b0;
        i_req = 1'b1;
        lat = 0;
        while (o_ack !== 1'b1 && lat < 300) begin
            @(posedge i_clk);
            #1;
            lat++;
        end
        if (lat >= 300) chk(32'h0, 32'h1);
        rdata = o_rdata;
        err = o_err;
        i_req = 1'b0;
    endtask : access

    task finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        {i_rst, i_req, i_write, i_size, i_addr, i_wdata, i_big_endian} = {1'b1, 69'h0};
        {i_bank_width, i_bank0_width_strap, i_ext_master_request, clr, wait_len} = 10'h280;
        {n_mismatch, num_checks, cyc, we_cnt} = '0;
        repeat (20) @(posedge i_clk);
        #1;
        chk(o_static_bank_select_n, 8'hff);
        chk({o_sdram_select_n, o_ext_master_grant, o_read_output_enable_n}, 4'hd);
        i_rst = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        chk(o_sdram_clk_en, 1'b1);
        k = 0;
        rdata[0] = o_sys_clock_out;
        repeat (8) begin
            @(posedge i_clk);
            #1;
            if (o_sys_clock_out !== rdata[0]) k++;
            rdata[0] = o_sys_clock_out;
        end
        chk(k, 8);
        done("reset");
        foreach (row_addr[r]) begin
            access(1'b0, 2'h2, row_addr[r], 32'h0);
            chk(sel_acc, row_sel[r]);
            chk(sd_acc, row_sd[r]);
            chk(err, row_sel[r] == 8'hff && row_sd[r] == 2'h3);
            chk(rc_seen, row_sd[r] != 2'h3);
            chk(oe_seen, row_sel[r] != 8'hff);
        end
        done("decode");
        access(1'b1, 2'h2, 32'h0100_0000, 32'ha1b2_c3d4);
        chk(mem, 32'ha1b2_c3d4);
        chk(oe_seen, 1'b0);
        i_big_endian = 1'b1;
        access(1'b1, 2'h2, 32'h0100_0000, 32'h1122_3344);
        chk(mem, 32'h4433_2211);
        chk(be_acc, 4'h0);
        access(1'b0, 2'h2, 32'h0100_0000, 32'h0);
        chk(rdata, 32'h1122_3344);
        access(1'b0, 2'h0, 32'h0100_0001, 32'h0);
        chk(rdata, 32'h2222_2222);
        access(1'b0, 2'h1, 32'h0100_0000, 32'h0);
        chk(rdata, 32'h1122_1122);
        for (k = 0; k < 4; k++) begin
            access(1'b1, 2'h0, 32'h0100_0000 + k, 32'h50 + k);
            chk(mem[8*k +: 8], 8'h50 + k);
            chk(be_acc, 4'(~(4'h1 << k)));
        end
        access(1'b1, 2'h1, 32'h0100_0002, 32'h0000_abcd);
        chk(mem, 32'hcdab_5150);
        chk(be_acc, 4'h3);
        i_big_endian = 1'b0;
        done("endian");
        i_bank0_width_strap = 2'h1;
        k = we_cnt;
        access(1'b1, 2'h2, 32'h0000_0010, 32'h0);
        chk(beats, 4'h2);
        chk(we_cnt != k, 1'b1);
        access(1'b1, 2'h2, 32'h0100_0010, 32'h0);
        chk(beats, 4'h1);
        i_bank_width = 2'h0;
        access(1'b1, 2'h2, 32'h0100_0010, 32'h0);
        chk(beats, 4'h4);
        access(1'b1, 2'h1, 32'h0100_0010, 32'h0);
        chk(beats, 4'h2);
        i_bank_width = 2'h2;
        done("width");
        access(1'b0, 2'h2, 32'h0100_0000, 32'h0);
        k = lat;
        wait_len = 4'hc;
        access(1'b0, 2'h2, 32'h0100_0000, 32'h0);
        chk(lat >= k + 8 && lat <= k + 16, 1'b1);
        wait_len = 4'h0;
        done("wait");
        i_ext_master_request = 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        chk(o_ext_master_grant, 1'b1);
        chk({o_addr_oe, o_data_oe, o_static_bank_select_n}, 10'h0ff);
        fork
            access(1'b0, 2'h2, 32'h0100_0000, 32'h0);
            begin
                repeat (12) @(posedge i_clk);
                #1;
                i_ext_master_request = 1'b0;
            end
        join
        chk(lat >= 11, 1'b1);
        chk(o_ext_master_grant, 1'b0);
        done("grant");
        finish_test();
    end
endmodule : tb
`default_nettype wire
